// [design/aia_pkg.sv]
// constants, types and helpers for the analog input allocation register bank
package aia_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NPARAM = 21;
    localparam int PW = 16;
    localparam int AW = 8;
    localparam int ADC_W = 12;

    // ****************************************
    // selector codes
    // ****************************************
    localparam logic [2:0] FN_NONE = 3'h0;
    localparam logic [2:0] FN_EXT_REF = 3'h1;
    localparam logic [2:0] FN_FEEDBACK = 3'h2;
    localparam logic [2:0] FN_OFFSET = 3'h3;
    localparam logic [2:0] FN_SETPOINT1 = 3'h4;
    localparam logic [31:0] FN_MAX = 32'h0000_0007;

    // ****************************************
    // parameter indices (word index = index + 1)
    // ****************************************
    localparam int IX_EXT_PPR = 0;
    localparam int IX_FB_PPR = 1;
    localparam int IX_AUX_PPR = 2;
    localparam int IX_P_EXT_MAX = 3;
    localparam int IX_P_FB_MAX = 4;
    localparam int IX_S_EXT_MAX = 5;
    localparam int IX_S_FB_MAX = 6;
    localparam int IX_P_AUX_MAX = 7;
    localparam int IX_S_AUX_MAX = 8;
    localparam int IX_ENG_FIRST = 9;
    localparam int IX_OFS_FIRST = 13;
    localparam int IX_OFS_LAST = 16;
    localparam int IX_SP_FIRST = 17;

    // ****************************************
    // byte offsets and word indices
    // ****************************************
    localparam logic [AW-1:0] OFS_FUNC_SELECT = 8'h00;
    localparam logic [AW-1:0] OFS_PARAM_BASE = 8'h04;
    localparam logic [AW-1:0] OFS_STATUS = 8'h58;
    localparam logic [AW-1:0] OFS_ANALOG = 8'h5C;
    localparam logic [5:0] WORD_STATUS = 6'h16;
    localparam logic [5:0] WORD_ANALOG = 6'h17;

    // ****************************************
    // forced values and reset values
    // ****************************************
    localparam logic [PW-1:0] FORCED_PPR = 16'h003C;
    localparam logic [PW-1:0] FORCED_MAX_SPEED = 16'h0FFF;
    localparam logic [ADC_W-1:0] FULL_SCALE_COUNT = 12'hFFF;
    localparam logic [PW-1:0] PARAM_RESET = 16'h0000;
    localparam logic [2:0] FUNC_RESET = 3'h0;

    typedef logic [NPARAM-1:0][PW-1:0] aia_param_vec_t;
    typedef logic [NPARAM-1:0] aia_mask_t;

    typedef struct packed {
        logic ext_ref_valid;
        logic feedback_valid;
        logic offset_valid;
        logic [3:0] setpoint_repl;
        logic [ADC_W-1:0] equiv_freq_hz;
    } aia_route_t;

    // which parameters a selector code takes over
    function automatic aia_mask_t aia_lock_mask(input logic [2:0] code);
        aia_mask_t m;
        m = '0;
        case (code)
            FN_EXT_REF: begin
                m[IX_EXT_PPR] = 1'b1;
                m[IX_P_EXT_MAX] = 1'b1;
                m[IX_S_EXT_MAX] = 1'b1;
            end
            FN_FEEDBACK: begin
                m[IX_FB_PPR] = 1'b1;
                m[IX_P_FB_MAX] = 1'b1;
            end
            FN_OFFSET: begin
                m[IX_P_AUX_MAX] = 1'b1;
                m[IX_S_AUX_MAX] = 1'b1;
            end
            default: begin
                m = '0;
            end
        endcase
        return m;
    endfunction : aia_lock_mask

endpackage : aia_pkg

// [design/aia_analog_route.sv]
// registered routing of the converter count to the allocated function
module aia_analog_route
    import aia_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [2:0] func_select, // current allocation code
    input wire logic [ADC_W-1:0] adc_count, // converter count
    output aia_route_t route // registered routing result
);

    logic [3:0] next_sp;

    always_comb begin
        next_sp = 4'h0;
        if (func_select >= FN_SETPOINT1) begin
            next_sp[2'(func_select - FN_SETPOINT1)] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            route <= '0;
        end else begin
            route.ext_ref_valid <= (func_select == FN_EXT_REF);
            route.feedback_valid <= (func_select == FN_FEEDBACK);
            route.offset_valid <= (func_select == FN_OFFSET);
            route.setpoint_repl <= next_sp;
            // count is taken 1:1 as Hz, so full scale gives the forced 4095 maximum
            route.equiv_freq_hz <= adc_count;
        end
    end

endmodule : aia_analog_route

// [design/aia_alloc_bank.sv]
// apb register bank for analog input allocation and the parameters it governs
//
// Implementation choices: the APB interface to the registers and the address map.
module aia_alloc_bank
    import aia_pkg::*;
(
    input wire logic core_clk, // system clock, 20 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [AW-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [ADC_W-1:0] adc_count, // analog converter count
    output logic [2:0] func_select, // stored allocation code
    output aia_param_vec_t params, // parameter values
    output aia_route_t route // analog routing
);

    // ****************************************
    // bus decode
    // ****************************************
    logic [5:0] word;
    logic aligned;
    logic param_hit;
    logic [4:0] pidx;
    logic access;
    logic wr;
    aia_mask_t locked;
    aia_mask_t new_lock;
    logic fsel_wr;
    logic fsel_ok;
    logic next_err;
    logic [31:0] next_rdata;
    logic last_reject;

    assign word = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign param_hit = aligned && (word >= 6'h01) && (word <= 6'(NPARAM));
    assign pidx = 5'(word - 6'h01);
    assign access = psel && penable && pready;
    assign wr = access && pwrite;
    assign locked = aia_lock_mask(func_select);
    assign fsel_wr = wr && aligned && (paddr == OFS_FUNC_SELECT);
    assign fsel_ok = (pwdata <= FN_MAX);
    assign new_lock = aia_lock_mask(pwdata[2:0]);

    // ****************************************
    // answer: registered at the setup edge, so pready rises in the access cycle
    // ****************************************
    always_comb begin
        next_err = 1'b0;
        next_rdata = 32'h0000_0000;
        if (!aligned) begin
            next_err = 1'b1;
        end else if (paddr == OFS_FUNC_SELECT) begin
            next_rdata = {29'h0, func_select};
            next_err = pwrite && !fsel_ok;
        end else if (param_hit) begin
            next_rdata = {16'h0, params[pidx]};
            next_err = pwrite && locked[pidx];
        end else if (word == WORD_STATUS) begin
            next_rdata = {last_reject, 10'h0, locked};
            next_err = pwrite;
        end else if (word == WORD_ANALOG) begin
            next_rdata = {20'h0, route.equiv_freq_hz};
            next_err = pwrite;
        end else begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    // ****************************************
    // allocation code
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            func_select <= FUNC_RESET;
        end else if (fsel_wr && fsel_ok) begin
            func_select <= pwdata[2:0];
        end
    end

    // sticky until the next accepted write; shows the last write was refused
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_reject <= 1'b0;
        end else if (wr) begin
            last_reject <= pslverr;
        end
    end

    // ****************************************
    // parameter registers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NPARAM; g++) begin : g_param
            logic own_wr;
            logic partner_clear;
            logic [PW-1:0] forced;
            assign forced = (g <= IX_AUX_PPR) ? FORCED_PPR : FORCED_MAX_SPEED;
            assign own_wr = wr && param_hit && (pidx == 5'(g)) && !locked[g];
            // positive and negative offsets of a pair are exclusive; pairs start at the first offset index
            assign partner_clear = (g >= IX_OFS_FIRST) && (g <= IX_OFS_LAST) && wr && param_hit
                && !locked[g] && (pidx == 5'(((g - IX_OFS_FIRST) ^ 1) + IX_OFS_FIRST))
                && (pwdata[PW-1:0] != PARAM_RESET);
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    params[g] <= PARAM_RESET;
                end else if (fsel_wr && fsel_ok && new_lock[g]) begin
                    params[g] <= forced;
                end else if (own_wr) begin
                    params[g] <= pwdata[PW-1:0];
                end else if (partner_clear) begin
                    params[g] <= PARAM_RESET;
                end
            end
        end
    endgenerate

    // ****************************************
    // analog routing
    // ****************************************
    aia_analog_route u_route (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .func_select(func_select),
        .adc_count(adc_count),
        .route(route)
    );

endmodule : aia_alloc_bank

// [test/aia_alloc_bank_assertions.sv]
// port checker for the allocation bank
module aia_alloc_bank_checker
    import aia_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset
    input wire logic psel, // sel
    input wire logic penable, // enable
    input wire logic pwrite, // dir
    input wire logic [AW-1:0] paddr, // addr
    input wire logic [31:0] pwdata, // wdata
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [ADC_W-1:0] adc_count, // count
    input wire logic [2:0] func_select, // code
    input wire aia_param_vec_t params, // params
    input wire aia_route_t route // route
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ws;
    assign ws = psel && penable && pready && pwrite && paddr == OFS_FUNC_SELECT;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    pulse_one_a: assert property (pready |=> !pready) else $error("ready too long");
    setup_ans_a: assert property (psel && !penable |=> pready) else $error("no answer");
    sel_refuse_a: assert property (ws && pwdata > FN_MAX |-> pslverr ##1 $stable(func_select))
        else $error("bad code taken");
    ext_force_a: assert property (ws && pwdata == 32'h1 |=> params[IX_EXT_PPR] == FORCED_PPR
        && params[IX_P_EXT_MAX] == FORCED_MAX_SPEED && params[IX_S_EXT_MAX] == FORCED_MAX_SPEED) else $error("code 1");
    fb_force_a: assert property (ws && pwdata == 32'h2 |=> params[IX_FB_PPR] == FORCED_PPR
        && params[IX_P_FB_MAX] == FORCED_MAX_SPEED) else $error("code 2");
    aux_force_a: assert property (ws && pwdata == 32'h3 |=> params[IX_P_AUX_MAX] == FORCED_MAX_SPEED
        && params[IX_S_AUX_MAX] == FORCED_MAX_SPEED) else $error("code 3");
    lock_keep_a: assert property (psel && penable && pwrite && paddr == OFS_PARAM_BASE
        && func_select == FN_EXT_REF |=> $stable(params[IX_EXT_PPR])) else $error("locked value moved");
    freq_track_a: assert property ($past(rst_n) |-> route.equiv_freq_hz == $past(adc_count))
        else $error("freq");
    ext_route_a: assert property (func_select == FN_EXT_REF |=> route.ext_ref_valid)
        else $error("ext route");
    sp_route_a: assert property (func_select[2] |=> route.setpoint_repl == 4'(4'h1 << $past(func_select[1:0])))
        else $error("setpoint route");
    ofs_pair_a: assert property ((params[IX_OFS_FIRST] == 16'h0000 || params[IX_OFS_FIRST + 1] == 16'h0000)
        && (params[IX_OFS_LAST - 1] == 16'h0000 || params[IX_OFS_LAST] == 16'h0000)) else $error("offset pair");
    cover property (ws && pwdata == 32'h1);
    cover property (ws && pslverr);
    cover property (func_select[2] ##1 route.setpoint_repl == 4'h8);
endmodule : aia_alloc_bank_checker

bind aia_alloc_bank aia_alloc_bank_checker i_aia_alloc_bank_checker(.core_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .adc_count, .func_select, .params, .route);

// [test/aia_host.sv]
// apb host that enters parameters into the bank
module aia_host
    import aia_pkg::*;
(
    input wire logic core_clk, // clock
    output logic psel, // sel
    output logic penable, // enable
    output logic pwrite, // dir
    output logic [AW-1:0] paddr, // addr
    output logic [31:0] pwdata, // wdata
    input wire logic [31:0] prdata, // rdata
    input wire logic pready, // ready
    input wire logic pslverr // error
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // psel stays up after a transfer so the next setup can follow at once
    task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // no cycle count assumed: a hang is ended by the bench watchdog
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
    endtask : xfer
    task automatic idle();
        psel <= 1'b0;
        @(posedge core_clk);
    endtask : idle
endmodule : aia_host

// [test/aia_alloc_bank_tb.sv]
// self-checking bench for the allocation bank
module aia_alloc_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aia_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [ADC_W-1:0] adc_count = '0;
    logic [2:0] func_select;
    aia_param_vec_t params;
    aia_route_t route;
    int failures = 0;
    int check_count = 0;
    logic [31:0] seed = 32'hD540;
    int ms = 0;
    int mp [NPARAM];
    bit lasterr = 0;
    always #25 core_clk = ~core_clk;
    aia_alloc_bank i_aia_alloc_bank(.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .adc_count, .func_select, .params, .route);
    aia_host i_aia_host(.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic bit lk(int i);
        return (ms == 1 && (i == 0 || i == 3 || i == 5)) || (ms == 2 && (i == 1 || i == 4))
            || (ms == 3 && (i == 7 || i == 8));
    endfunction : lk
    function automatic logic [31:0] mrd(int a);
        logic [31:0] v;
        v = '0;
        if (a == 0) v = ms;
        else if (a < 8'h58) v = mp[(a - 4) / 4];
        else if (a == 8'h58) begin
            v[31] = lasterr;
            for (int i = 0; i < NPARAM; i++) v[i] = lk(i);
        end else if (a == 8'h5C) v = adc_count;
        return v;
    endfunction : mrd
    function automatic bit mwr(int a, int d);
        int i;
        i = (a - 4) / 4;
        if (a % 4 != 0 || a >= 8'h58 || (a == 0 && d[31:0] > 7) || (a > 0 && lk(i))) return 1'b1;
        if (a == 0) begin
            ms = d;
            for (int k = 0; k < NPARAM; k++) if (lk(k)) mp[k] = (k < 3) ? 60 : 4095;
        end else begin
            mp[i] = d & 32'h0000FFFF;
            if (i >= IX_OFS_FIRST && i <= IX_OFS_LAST && mp[i] != 0) mp[i + ((i % 2) ? 1 : -1)] = 0;
        end
        return 1'b0;
    endfunction : mwr
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk
    task automatic acc(input bit w, input int a, input int d);
        logic [31:0] rd, ev;
        logic err;
        bit ee;
        ev = mrd(a);
        ee = w ? mwr(a, d) : (a % 4 != 0 || a > 8'h5C);
        if (w) lasterr = ee;
        i_aia_host.xfer(w, a[AW-1:0], d, rd, err);
        chk("pslverr", {31'h0, ee}, {31'h0, err});
        if (!w && !ee) chk("prdata", ev, rd);
    endtask : acc
    task automatic readall();
        for (int a = 0; a <= 8'h60; a += 4) acc(0, a, 0);
        acc(0, 2, 0);
    endtask : readall
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial begin
        #400000;
        failures++;
        complete_run();
    end
    initial begin
        foreach (mp[i]) mp[i] = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        readall();
        $display("test reset done");
        for (int i = 0; i < NPARAM; i++) acc(1, 4 + 4 * i, rnd());
        acc(1, 4 + 4 * IX_ENG_FIRST, 2 * 15);
        readall();
        $display("test params done");
        for (int c = 0; c < 16; c++) begin
            acc(1, 0, c);
            for (int i = 0; i < NPARAM; i++) acc(1, 4 + 4 * i, rnd());
            acc(1, 8'h58, rnd());
            adc_count <= (c == 1) ? FULL_SCALE_COUNT : ADC_W'(rnd());
            i_aia_host.idle();
            @(posedge core_clk);
            chk("route", {13'h0, ms == 1, ms == 2, ms == 3, ms >= 4 ? 4'(1 << (ms - 4)) : 4'h0, adc_count},
                {13'h0, route});
            chk("func_select", ms, {29'h0, func_select});
            for (int i = 0; i < NPARAM; i++) chk("params", mp[i], {16'h0, params[i]});
            readall();
        end
        $display("test codes done");
        i_aia_host.idle();
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        ms = 0;
        lasterr = 0;
        foreach (mp[i]) mp[i] = 0;
        @(posedge core_clk);
        readall();
        $display("test reset again done");
        complete_run();
    end
endmodule : aia_alloc_bank_tb
